// file: rtl/rxhwc_top.sv
/*
 * receive hardware-mode control: equaliser enables, mute on loss of
 * signal, threshold set select, interrupt pin in serial host mode.
 * assumes recovered data, bit strobes, loss-of-signal and rate flags
 * arrive on i_ref_clk; strap pins are asynchronous; pad pull-downs
 * and pin drivers sit outside.
 */
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps

module rxhwc_top #(
   parameter int NUM_CH = 3
) (
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_reset_n,
   input  wire logic [NUM_CH-1:0]           i_rx_equalizer_enable_pin,
   input  wire logic                        i_los_mute_select,
   output logic                             o_los_mute_select,
   output logic                             o_los_mute_select_oe_n,
   input  wire logic                        i_los_threshold_select,
   input  wire logic                        i_host_mode_pin,
   input  wire logic [NUM_CH-1:0]           i_rate_ds3_sts1,
   input  wire logic [NUM_CH-1:0]           i_los_declared,
   input  wire logic [NUM_CH-1:0]           i_rx_bit_strobe,
   input  wire logic [NUM_CH-1:0]           i_rx_pos,
   input  wire logic [NUM_CH-1:0]           i_rx_neg,
   output logic [NUM_CH-1:0]                o_rx_positive_data_out,
   output logic [NUM_CH-1:0]                o_rx_negative_data_out,
   output logic [NUM_CH-1:0]                o_eq_enable,
   output logic                             o_los_thr_high,
   output logic                             o_los_thr_active,
   input  wire logic [rxhwc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [rxhwc_pkg::DATA_W-1:0] i_wr_data,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic [rxhwc_pkg::DATA_W-1:0]     o_rd_data,
   output logic                             o_irq
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (NUM_CH < 1 || NUM_CH > rxhwc_pkg::MAX_CH) begin : g_bad_ch
      $error("NUM_CH must be 1 to 8");
   end

   localparam int PW      = NUM_CH + 3;
   localparam int P_MUTE  = NUM_CH;
   localparam int P_THR   = NUM_CH + 1;
   localparam int P_HOST  = NUM_CH + 2;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PW-1:0]     s1;
      logic [PW-1:0]     s2;
      logic [PW-1:0]     s3;
      logic [PW-1:0]     pin;
      logic [NUM_CH-1:0] mute;
      logic [NUM_CH-1:0] los_p;
      logic [NUM_CH-1:0] pos;
      logic [NUM_CH-1:0] neg;
      logic [NUM_CH-1:0] eq;
      logic              thr;
      logic              thr_act;
      logic [15:0]       ctrl;
      logic [15:0]       istat;
      logic [15:0]       imask;
      logic [15:0]       rdata;
   } rxhwc_state_t;

   rxhwc_state_t q;
   rxhwc_state_t d;

   // settled value: follows stage two once stages two and three agree
   function automatic logic [PW-1:0] settle(
      input logic [PW-1:0] a,
      input logic [PW-1:0] b,
      input logic [PW-1:0] old
   );
      logic [PW-1:0] diff;
      diff   = a ^ b;
      settle = (a & ~diff) | (old & diff);
   endfunction

   logic              host;
   logic              mute_en;
   logic              irq;
   logic [NUM_CH-1:0] ev_decl;
   logic [NUM_CH-1:0] ev_clr;

   assign host    = q.pin[P_HOST];
   assign irq     = |(q.istat & q.imask);
   assign ev_decl = i_los_declared & ~q.los_p;
   assign ev_clr  = ~i_los_declared & q.los_p;

   // one global mute enable for every channel
   assign mute_en = host ? q.ctrl[rxhwc_pkg::CTRL_MUTE_BIT] : q.pin[P_MUTE];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] ev;
      logic        m;
      ev = '0;
      m  = 1'b0;
      d  = q;

      d.s1  = {i_host_mode_pin, i_los_threshold_select,
               i_los_mute_select, i_rx_equalizer_enable_pin};
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.pin = settle(q.s2, q.s3, q.pin);

      // equaliser from pins in hardware mode, from register in host mode
      if (host) begin
         d.eq = q.ctrl[rxhwc_pkg::CTRL_EQ_LSB +: NUM_CH];
      end else begin
         d.eq = q.pin[NUM_CH-1:0];
      end

      // threshold set only applies with a DS3 or STS-1 channel
      d.thr_act = |i_rate_ds3_sts1;
      d.thr     = (|i_rate_ds3_sts1) & q.pin[P_THR];

      // mute state and data move only on a recovered bit edge
      for (int c = 0; c < NUM_CH; c++) begin
         if (i_rx_bit_strobe[c]) begin
            m         = mute_en & i_los_declared[c];
            d.mute[c] = m;
            d.pos[c]  = i_rx_pos[c] & ~m;
            d.neg[c]  = i_rx_neg[c] & ~m;
         end
      end

      // loss-of-signal edges feed sticky status; set beats clear
      d.los_p = i_los_declared;
      ev[rxhwc_pkg::INT_DECL_LSB +: NUM_CH] = ev_decl;
      ev[rxhwc_pkg::INT_CLR_LSB  +: NUM_CH] = ev_clr;
      d.istat = q.istat | ev;
      if (i_wr) begin
         case (i_addr)
            rxhwc_pkg::ADDR_CTRL: begin
               d.ctrl = i_wr_data;
            end
            rxhwc_pkg::ADDR_ISTAT: begin
               d.istat = (q.istat & ~i_wr_data) | ev;
            end
            rxhwc_pkg::ADDR_IMASK: begin
               d.imask = i_wr_data;
            end
            default: begin
               d.ctrl = q.ctrl;
            end
         endcase
      end

      // read data stand for one cycle only
      d.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            rxhwc_pkg::ADDR_CTRL: begin
               d.rdata = q.ctrl;
            end
            rxhwc_pkg::ADDR_STAT: begin
               d.rdata[rxhwc_pkg::STAT_LOS_LSB +: NUM_CH] = i_los_declared;
               d.rdata[rxhwc_pkg::STAT_HOST_BIT]          = host;
               d.rdata[rxhwc_pkg::STAT_MUTE_BIT]          = mute_en;
               d.rdata[rxhwc_pkg::STAT_THR_BIT]           = q.thr;
               d.rdata[rxhwc_pkg::STAT_THRACT_BIT]        = q.thr_act;
            end
            rxhwc_pkg::ADDR_ISTAT: begin
               d.rdata = q.istat;
            end
            rxhwc_pkg::ADDR_IMASK: begin
               d.rdata = q.imask;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q       <= '0;
         q.ctrl  <= rxhwc_pkg::CTRL_RST;
         q.istat <= rxhwc_pkg::ISTAT_RST;
         q.imask <= rxhwc_pkg::IMASK_RST;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_rx_positive_data_out = q.pos;
   assign o_rx_negative_data_out = q.neg;
   assign o_eq_enable            = q.eq;
   assign o_los_thr_high         = q.thr;
   assign o_los_thr_active       = q.thr_act;
   assign o_rd_data              = q.rdata;
   assign o_irq                  = irq;

   // mute pin turns into the interrupt request in host mode
   assign o_los_mute_select      = host & irq;
   assign o_los_mute_select_oe_n = ~host;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_eq_pin_follow: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !host |=> (q.eq == $past(q.pin[NUM_CH-1:0])))
      else $error("equaliser does not follow its pin");

   chk_eq_host_ignore: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      host |=> (o_eq_enable == $past(q.ctrl[rxhwc_pkg::CTRL_EQ_LSB +: NUM_CH])))
      else $error("equaliser follows pin in host mode");

   chk_eq_start_off: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (q.pin[NUM_CH-1:0] == '0 && !host) |=> (o_eq_enable == '0))
      else $error("equaliser enabled with low pins");

   chk_irq_pin_drive: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      host |-> (!o_los_mute_select_oe_n && o_los_mute_select == o_irq))
      else $error("mute pin not driving interrupt in host mode");

   chk_thr_gate: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_rate_ds3_sts1 == '0) |=> (!o_los_thr_high && !o_los_thr_active))
      else $error("threshold select active without DS3 or STS-1");

   chk_thr_select: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (|i_rate_ds3_sts1) |=> (o_los_thr_high == $past(q.pin[P_THR])))
      else $error("threshold set differs from select pin");

   chk_mute_global: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (mute_en && (&i_rx_bit_strobe) && (&i_los_declared)) |=> (&q.mute))
      else $error("mute not applied to every channel");

   // ---------------------------------------------------------------
   // interrupt, bus and per-channel data checks
   // ---------------------------------------------------------------
   chk_pin_released: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !host |-> (o_los_mute_select_oe_n && !o_los_mute_select))
      else $error("mute pin driven in hardware mode");

   chk_int_sticky: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      ev_decl[0] |=> q.istat[rxhwc_pkg::INT_DECL_LSB]
         ##1 (q.istat[rxhwc_pkg::INT_DECL_LSB] || $past(i_wr && i_addr == rxhwc_pkg::ADDR_ISTAT)))
      else $error("loss event lost from status");

   chk_set_wins: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (ev_clr[0] && i_wr && i_addr == rxhwc_pkg::ADDR_ISTAT) |=> q.istat[rxhwc_pkg::INT_CLR_LSB])
      else $error("status clear beat a new loss event");

   chk_w1c_clear: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == rxhwc_pkg::ADDR_ISTAT && i_wr_data[rxhwc_pkg::INT_DECL_LSB] && !ev_decl[0])
      |=> !q.istat[rxhwc_pkg::INT_DECL_LSB])
      else $error("status bit not cleared by writing one");

   chk_rd_idle: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_rd |=> (o_rd_data == '0))
      else $error("read data stand beyond one cycle");

   chk_ctrl_write: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == rxhwc_pkg::ADDR_CTRL) |=> (q.ctrl == $past(i_wr_data)))
      else $error("control write lost");

   chk_mask_write: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == rxhwc_pkg::ADDR_IMASK) |=> (q.imask == $past(i_wr_data)))
      else $error("mask write lost");

   chk_stat_host: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == rxhwc_pkg::ADDR_STAT) |=> (o_rd_data[rxhwc_pkg::STAT_HOST_BIT] == $past(host)
         && o_rd_data[rxhwc_pkg::STAT_MUTE_BIT] == $past(mute_en)))
      else $error("status shows wrong mode or mute enable");

   for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
      chk_mute_low: assert property (
         @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_rx_bit_strobe[c] && mute_en && i_los_declared[c])
         |=> (!o_rx_positive_data_out[c] && !o_rx_negative_data_out[c]))
         else $error("data not muted during loss of signal");

      chk_no_mute: assert property (
         @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_rx_bit_strobe[c] && !mute_en)
         |=> (o_rx_positive_data_out[c] == $past(i_rx_pos[c])
              && o_rx_negative_data_out[c] == $past(i_rx_neg[c])))
         else $error("data muted with mute select low");

      chk_bit_hold: assert property (
         @(posedge i_ref_clk) disable iff (!i_reset_n)
         !i_rx_bit_strobe[c] |=> ($stable(o_rx_positive_data_out[c])
            && $stable(o_rx_negative_data_out[c]) && $stable(q.mute[c])))
         else $error("data or mute changed between bit edges");

      chk_unmute_clear: assert property (
         @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_rx_bit_strobe[c] && !i_los_declared[c])
         |=> (o_rx_positive_data_out[c] == $past(i_rx_pos[c])
              && o_rx_negative_data_out[c] == $past(i_rx_neg[c])))
         else $error("data still muted after loss of signal cleared");

      chk_mute_state: assert property (
         @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_rx_bit_strobe[c] |=> (q.mute[c] == $past(mute_en && i_los_declared[c])))
         else $error("mute state not taken at bit edge");
   end

endmodule

// file: rtl/rxhwc_pkg.sv
/*
 * constants for the receive hardware-mode control block:
 * register offsets, field positions, reset values, synchroniser depth.
 * assumes a 4-bit word address and 16-bit register data.
 */
package rxhwc_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_STAT  = 4'h4;
   localparam logic [3:0] ADDR_ISTAT = 4'h8;
   localparam logic [3:0] ADDR_IMASK = 4'hc;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_EQ_LSB     = 0;
   localparam int CTRL_MUTE_BIT   = 8;
   localparam int STAT_LOS_LSB    = 0;
   localparam int STAT_HOST_BIT   = 8;
   localparam int STAT_MUTE_BIT   = 9;
   localparam int STAT_THR_BIT    = 10;
   localparam int STAT_THRACT_BIT = 11;
   localparam int INT_DECL_LSB    = 0;
   localparam int INT_CLR_LSB     = 8;

   // ---------------------------------------------------------------
   // reset values and limits
   // ---------------------------------------------------------------
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] IMASK_RST = 16'h0000;
   localparam logic [15:0] ISTAT_RST = 16'h0000;
   localparam int          MAX_CH    = 8;
   localparam int          SYNC_N    = 3;

endpackage

// file: test/rxhwc_straps.sv
/* board strap model for the equaliser enable pins.
   assumes the bench picks which pins are driven and to what level. */
`timescale 1ns/1ps
module rxhwc_straps (
   input  wire logic       i_host_mode,
   input  wire logic [2:0] i_drive_en,
   input  wire logic [2:0] i_drive_val,
   output logic      [2:0] o_pin
);
   // ------------------------------
   // strap pins with pad pull-down
   // ------------------------------
   // board ties the pins to ground in host mode
   assign o_pin = i_host_mode ? 3'b000 : (i_drive_en & i_drive_val);
endmodule

// file: test/rxhwc_top_tb.sv
/* self-checking bench for rxhwc_top: straps, muting, threshold select,
   host mode and interrupt pin.
   assumes rtl package and top are compiled before this file. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module rxhwc_top_tb;
   logic        i_ref_clk = 0;
   logic        i_reset_n = 0;
   logic [2:0]  eq_en, eq_val, eq_pin, rate, los, stb, pos, neg, pos_o, neg_o, eq_o;
   logic        mute_drv, thr, host, wr, rd, stb_was, rd_was;
   logic        mute_o, mute_oe_n, thr_hi, thr_act, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, exp16;
   logic [5:0]  exp6;
   logic [5:0]  dq[$];
   logic [15:0] rq[$];
   int          bad_count = 0;
   int          n_checks = 0;
   int          seed = 32'h4107_bb5c;
   wire         mute_pin = mute_oe_n ? mute_drv : mute_o;

   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   rxhwc_straps u_straps (.i_host_mode(host), .i_drive_en(eq_en), .i_drive_val(eq_val), .o_pin(eq_pin));

   rxhwc_top #(.NUM_CH(3)) u_dut (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_rx_equalizer_enable_pin(eq_pin),
      .i_los_mute_select(mute_pin), .o_los_mute_select(mute_o), .o_los_mute_select_oe_n(mute_oe_n),
      .i_los_threshold_select(thr), .i_host_mode_pin(host), .i_rate_ds3_sts1(rate),
      .i_los_declared(los), .i_rx_bit_strobe(stb), .i_rx_pos(pos), .i_rx_neg(neg),
      .o_rx_positive_data_out(pos_o), .o_rx_negative_data_out(neg_o), .o_eq_enable(eq_o),
      .o_los_thr_high(thr_hi), .o_los_thr_active(thr_act), .i_addr(addr), .i_wr_data(wdata),
      .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .o_irq(irq));

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic complete_run;
      bad_count += dq.size() + rq.size();
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge i_ref_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_ref_clk);
      addr <= a; rd <= 1'b1;
      rq.push_back(e);
      @(posedge i_ref_clk);
      rd <= 1'b0;
   endtask

   task automatic burst(input logic m);
      logic [8:0] v;
      for (int k = 0; k < 8; k++) begin
         @(posedge i_ref_clk);
         v = 9'($random(seed));
         pos <= v[2:0]; neg <= v[5:3]; los <= v[8:6]; stb <= 3'b111;
         dq.push_back({v[2:0] & ~({3{m}} & v[8:6]), v[5:3] & ~({3{m}} & v[8:6])});
      end
      @(posedge i_ref_clk);
      stb <= 3'b000; los <= 3'b000;
      wt(2);
   endtask

   // ------------------------------
   // output monitor
   // ------------------------------
   always @(posedge i_ref_clk) begin
      stb_was <= |stb;
      rd_was  <= rd;
   end

   always @(negedge i_ref_clk) begin
      if (stb_was) begin
         exp6 = (dq.size() > 0) ? dq.pop_front() : 'x;
         `CHK({pos_o, neg_o}, exp6)
      end
      if (rd_was) begin
         exp16 = (rq.size() > 0) ? rq.pop_front() : 'x;
         `CHK(rdata, exp16)
      end
   end

   initial begin
      repeat (5000) @(posedge i_ref_clk);
      bad_count++;
      complete_run;
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      {eq_en, eq_val, rate, los, stb, pos, neg, mute_drv, thr, host, wr, rd, addr, wdata} = '0;
      repeat (2) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      eq_en <= 3'($random(seed));
      eq_val <= 3'($random(seed));
      wt(6);
      `CHK({mute_oe_n, eq_o}, {1'b1, eq_en & eq_val})
      for (int m = 0; m < 2; m++) begin
         @(posedge i_ref_clk);
         mute_drv <= m[0];
         wt(6);
         burst(m[0]);
      end
      @(posedge i_ref_clk);
      thr <= 1'b1;
      wt(6);
      `CHK({thr_hi, thr_act}, 2'b00)
      @(posedge i_ref_clk);
      rate <= 3'b010;
      wt(6);
      `CHK({thr_hi, thr_act}, 2'b11)
      @(posedge i_ref_clk);
      thr <= 1'b0;
      wt(6);
      `CHK({thr_hi, thr_act}, 2'b01)
      @(posedge i_ref_clk);
      host <= 1'b1; eq_en <= 3'b111; eq_val <= 3'b111; mute_drv <= 1'b0;
      wt(6);
      `CHK({mute_oe_n, eq_o}, 4'b0000)
      wr_reg(rxhwc_pkg::ADDR_CTRL, 16'h0105);
      wt(2);
      `CHK(eq_o, 3'b101)
      rd_reg(rxhwc_pkg::ADDR_CTRL, 16'h0105);
      burst(1'b1);
      wr_reg(rxhwc_pkg::ADDR_ISTAT, 16'hffff);
      rd_reg(rxhwc_pkg::ADDR_ISTAT, 16'h0000);
      @(posedge i_ref_clk);
      los <= 3'b001;
      wt(3);
      rd_reg(rxhwc_pkg::ADDR_ISTAT, 16'h0001);
      wt(1);
      `CHK({irq, mute_pin}, 2'b00)
      wr_reg(rxhwc_pkg::ADDR_IMASK, 16'h0001);
      wt(2);
      `CHK({irq, mute_pin}, 2'b11)
      rd_reg(rxhwc_pkg::ADDR_IMASK, 16'h0001);
      rd_reg(rxhwc_pkg::ADDR_STAT, 16'h0b01);
      wr_reg(rxhwc_pkg::ADDR_ISTAT, 16'h0001);
      wt(2);
      `CHK({irq, mute_pin}, 2'b00)
      // loss clears in the same cycle as a write-one-to-clear: the event wins
      @(posedge i_ref_clk);
      addr <= rxhwc_pkg::ADDR_ISTAT;
      wdata <= 16'hffff;
      wr <= 1'b1;
      los <= 3'b000;
      @(posedge i_ref_clk);
      wr <= 1'b0;
      rd_reg(rxhwc_pkg::ADDR_ISTAT, 16'h0100);
      rd_reg(4'h2, 16'h0000);
      wt(2);
      complete_run;
   end
endmodule
